//--- hdl/bci_pkg.sv
// package for the bridge control and indirect access register bank
// assumes one 10 MHz device clock; register map offsets are byte addresses on the plain port, STATUS_OFFSET is a byte inside each page
package bci_pkg;
  // register offsets
  localparam logic [7:0] ADDR_INDIRECT_CONTROL = 8'h40;
  localparam logic [7:0] ADDR_INDIRECT_OFFSET = 8'h41;
  localparam logic [7:0] ADDR_INDIRECT_DATA = 8'h42;
  localparam logic [7:0] ADDR_PORT_CONTROL = 8'h4e;
  localparam logic [7:0] ADDR_BRIDGE_CONTROL = 8'h4f;
  localparam logic [7:0] ADDR_BRIDGE_STATUS = 8'h50;

  // indirect control fields
  localparam int POS_READ_MODE = 0;
  localparam int POS_AUTO_INC = 1;
  localparam int POS_PAGE_LO = 2;
  localparam int POS_PAGE_HI = 4;

  // port control fields (target port, independent two-in two-out mode)
  localparam int POS_TARGET_PORT = 0;
  localparam int POS_INDEPENDENT = 1;

  // bridge control fields
  localparam int POS_CONT_CLK = 7;
  localparam int POS_DUAL_INPUT = 6;
  localparam int POS_INPUT_SEL = 5;
  localparam int POS_ALT_3D = 4;
  localparam int POS_LANES_HI = 3;
  localparam int POS_LANES_LO = 2;
  localparam int POS_CFG_INIT = 1;

  // bridge status fields
  localparam int POS_INIT_DONE = 4;
  localparam int POS_CFG_DONE = 2;
  localparam int POS_CKSUM_OK = 1;

  // reset values
  localparam logic [7:0] RESET_INDIRECT_CONTROL = 8'h00;
  localparam logic [7:0] RESET_INDIRECT_OFFSET = 8'h00;
  localparam logic [7:0] RESET_BRIDGE_STATUS = 8'h02;
  localparam logic [1:0] RESET_PORT_CONTROL = 2'h0;

  // receiver status register inside each digital page
  localparam logic [7:0] STATUS_OFFSET = 8'hf0;

  // page select codes
  typedef enum logic [2:0] {
    BCI_PAGE_OFF = 3'b000,
    BCI_PAGE_PORT0 = 3'b001,
    BCI_PAGE_PORT1 = 3'b010
  } bci_page_t;

  // configuration reload duration
  localparam int RELOAD_TIME_NS = 1600;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RELOAD_CYCLES = (RELOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : bci_pkg

//--- hdl/bci_top.sv
// bridge control register bank with an indirect window into per-port receiver pages
// assumes a plain register port on clk, straps arriving asynchronously from pins
//
// Summary of operation
// - offset register holds 8-bit offset of next indirect target inside page
// - writing data register writes that byte to addressed register in page
// - reading data register returns addressed register contents in page
// - continuous clock bit 7 set means clock lane always high speed
// - continuous clock bit starts from strap b after reset
// - in independent mode, clock and lane fields act on selected port
// - bit 6 chooses dual input when set, single input when clear
// - in single input, bit 5 chooses input port 0 or 1
// - in independent mode, bit 5 set crosses input to output routing
// - bit 4 merges alternate line 3d video into alternate pixels
// - lane field bits 3-2 enable one to four lanes
// - lane field loads from strap a after reset
// - writing 1 to bit 1 starts configuration reload
// - reload restores strap fields to originally sampled strap values
// - bit 1 clears itself when the reload finishes
// - page select 000 off, 001 port 0, 010 port 1, others reserved
// - auto increment advances offset by one after each indirect access
// - read mode set makes status reads clear, else reads leave them
//
// register map on the plain port
//   0x40 indirect control: bits 4:2 page, bit 1 auto increment, bit 0 read mode
//   0x41 indirect offset, byte inside the selected page
//   0x42 indirect data window into the selected page
//   0x4e port control: bit 0 target port, bit 1 independent two-in two-out
//   0x4f bridge control, strap fields kept per output port
//   0x50 bridge status: bit 4 init done, bit 2 cfg done, bit 1 checksum good
//   every other address reads zero and drops writes
//
// bridge control layout
//   bit 7 continuous clock, bit 6 dual input, bit 5 input select
//   bit 4 alternate line 3d, bits 3:2 lane count
//   bit 1 reload request, reads back as reload busy; bit 0 reads zero
//
// reload behaviour
//   reset release starts a reload that catches the synchronised straps
//   a software reload restores those first caught values, not the live pins
//   strap field writes are dropped while a reload runs
//   the reload lasts a fixed number of cycles set in the package
//   cfg done rises at the finishing edge, init done one cycle later
//
// limitations
//   page storage has no reset; software writes a byte before reading it
//   offset 0xf0 of each page is the sticky receiver status and is read only
//   auto increment wraps from 0xff to 0x00 with no flag
//   nothing stops software changing lanes while video is arriving
//   the transmit mode for split 3d outputs lives outside this bank
//
// hazards
//   straps must be steady for four cycles before the first reload ends
//   an event in the clearing read cycle stays set, so none is lost
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module bci_top (
  input wire logic clk, // 10 MHz device clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic [7:0] addr, // register byte address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire logic [1:0] mode_strap_a, // lane count strap pins
  input wire logic mode_strap_b, // continuous clock strap pin
  input wire logic cksum_ok, // reload checksum result
  input wire logic [7:0] rx_event_p0, // port 0 receiver status events
  input wire logic [7:0] rx_event_p1, // port 1 receiver status events
  output logic [1:0] continuous_clk, // per-port clock lane mode
  output logic [3:0] lane_enable_p0, // port 0 active lanes
  output logic [3:0] lane_enable_p1, // port 1 active lanes
  output logic dual_input_enable, // dual input receive mode
  output logic active_input_port, // single input: active port
  output logic port_swap, // independent mode: crossed routing
  output logic alternate_line_3d, // alternate line 3d merge
  output logic reload_busy // configuration reload in progress
);
  // lane field to lane enables
  // thermometer code, lane 0 always on; every code is legal
  function automatic logic [3:0] lane_decode(input logic [1:0] code);
    unique case (code)
      2'h0: lane_decode = 4'h1;
      2'h1: lane_decode = 4'h3;
      2'h2: lane_decode = 4'h7;
      2'h3: lane_decode = 4'hf;
    endcase
  endfunction : lane_decode

  // software visible state
  logic [7:0] indirect_control;
  logic [7:0] indirect_offset;
  logic [1:0] port_control;
  logic [1:0] cont_clk;
  logic [1:0] lanes [2];
  logic dual_input;
  logic input_sel;
  logic alt_3d;
  logic [7:0] bridge_status;
  logic [7:0] page_mem [2][256];
  logic [7:0] rx_status [2];
  // strap synchroniser stages and the values caught at the first reload
  logic [1:0] strap_a_s1, strap_a_s2, strap_a_s3;
  logic strap_b_s1, strap_b_s2, strap_b_s3;
  logic [1:0] strap_a_stable;
  logic strap_b_stable;
  logic [1:0] strap_a_sampled;
  logic strap_b_sampled;
  // reload sequencer
  logic first_load;
  logic busy;
  logic [7:0] reload_count;
  logic init_pending;

  // decoded strobes and page selection
  // a refused page blocks both strobes before any state sees them
  logic [2:0] page_code;
  logic page_valid;
  logic page_port;
  logic tgt;
  logic wr_data, rd_data, wr_ctl, finish;
  logic [7:0] win_value;
  logic [1:0] strap_a_src;
  logic strap_b_src;

  always_comb begin
    page_code = indirect_control[bci_pkg::POS_PAGE_HI:bci_pkg::POS_PAGE_LO];
    page_valid = (page_code == bci_pkg::BCI_PAGE_PORT0) ||
                 (page_code == bci_pkg::BCI_PAGE_PORT1);
    page_port = (page_code == bci_pkg::BCI_PAGE_PORT1);
    // only independent mode makes the selected port matter
    tgt = port_control[bci_pkg::POS_INDEPENDENT] & port_control[bci_pkg::POS_TARGET_PORT];
    wr_data = wr && (addr == bci_pkg::ADDR_INDIRECT_DATA) && page_valid;
    rd_data = rd && (addr == bci_pkg::ADDR_INDIRECT_DATA) && page_valid;
    wr_ctl = wr && (addr == bci_pkg::ADDR_BRIDGE_CONTROL);
    finish = busy && (reload_count == 8'(bci_pkg::RELOAD_CYCLES - 1));
    strap_a_src = first_load ? strap_a_stable : strap_a_sampled;
    strap_b_src = first_load ? strap_b_stable : strap_b_sampled;
    if (indirect_offset == bci_pkg::STATUS_OFFSET) begin
      win_value = rx_status[page_port];
    end else begin
      win_value = page_mem[page_port][indirect_offset];
    end
  end

  // strap synchronisers; a change counts once stages two and three agree
  // stage one feeds only stage two, so a metastable value goes no further
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_a_s1 <= 2'h0;
      strap_a_s2 <= 2'h0;
      strap_a_s3 <= 2'h0;
      strap_b_s1 <= 1'b0;
      strap_b_s2 <= 1'b0;
      strap_b_s3 <= 1'b0;
      strap_a_stable <= 2'h0;
      strap_b_stable <= 1'b0;
    end else begin
      strap_a_s1 <= mode_strap_a;
      strap_a_s2 <= strap_a_s1;
      strap_a_s3 <= strap_a_s2;
      strap_b_s1 <= mode_strap_b;
      strap_b_s2 <= strap_b_s1;
      strap_b_s3 <= strap_b_s2;
      if (strap_a_s2 == strap_a_s3) begin
        strap_a_stable <= strap_a_s3;
      end
      if (strap_b_s2 == strap_b_s3) begin
        strap_b_stable <= strap_b_s3;
      end
    end
  end

  // reload sequencer; reset starts one so the pipeline settles before straps are caught
  // a reload request while busy is dropped; the running reload
  // finishes on its own count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b1;
      reload_count <= 8'h00;
      first_load <= 1'b1;
      strap_a_sampled <= 2'h0;
      strap_b_sampled <= 1'b0;
    end else if (finish) begin
      busy <= 1'b0;
      reload_count <= 8'h00;
      first_load <= 1'b0;
      if (first_load) begin
        strap_a_sampled <= strap_a_stable;
        strap_b_sampled <= strap_b_stable;
      end
    end else if (busy) begin
      reload_count <= reload_count + 8'h01;
    end else if (wr_ctl && wdata[bci_pkg::POS_CFG_INIT]) begin
      busy <= 1'b1;
    end
  end

  // bridge status: done flags drop at reload start, cfg then init on finish
  // the checksum bit is taken at the finishing edge only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bridge_status <= bci_pkg::RESET_BRIDGE_STATUS;
      init_pending <= 1'b0;
    end else begin
      init_pending <= finish;
      if (finish) begin
        bridge_status[bci_pkg::POS_CFG_DONE] <= 1'b1;
        bridge_status[bci_pkg::POS_CKSUM_OK] <= cksum_ok;
      end else if (busy) begin
        bridge_status[bci_pkg::POS_CFG_DONE] <= 1'b0;
      end
      if (init_pending) begin
        bridge_status[bci_pkg::POS_INIT_DONE] <= 1'b1;
      end else if (busy) begin
        bridge_status[bci_pkg::POS_INIT_DONE] <= 1'b0;
      end
    end
  end

  // strap fields: forced from straps while reloading, else written per target port
  // busy wins over a write in the same cycle, so software
  // cannot race the restore
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cont_clk <= 2'h0;
      lanes[0] <= 2'h0;
      lanes[1] <= 2'h0;
    end else if (busy) begin
      cont_clk <= {strap_b_src, strap_b_src};
      lanes[0] <= strap_a_src;
      lanes[1] <= strap_a_src;
    end else if (wr_ctl) begin
      cont_clk[tgt] <= wdata[bci_pkg::POS_CONT_CLK];
      lanes[tgt] <= wdata[bci_pkg::POS_LANES_HI:bci_pkg::POS_LANES_LO];
    end
  end

  // plain bridge control fields
  // no strap behind these, so they stay writable during a reload
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dual_input <= 1'b0;
      input_sel <= 1'b0;
      alt_3d <= 1'b0;
    end else if (wr_ctl) begin
      dual_input <= wdata[bci_pkg::POS_DUAL_INPUT];
      input_sel <= wdata[bci_pkg::POS_INPUT_SEL];
      alt_3d <= wdata[bci_pkg::POS_ALT_3D];
    end
  end

  // indirect control and port control
  // reserved bits 7:5 of indirect control always read zero
  // port control chooses which output port the strap fields act on
  // in independent mode; outside that mode port 0 is always used
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      indirect_control <= bci_pkg::RESET_INDIRECT_CONTROL;
      port_control <= bci_pkg::RESET_PORT_CONTROL;
    end else if (wr && addr == bci_pkg::ADDR_INDIRECT_CONTROL) begin
      indirect_control <= {3'h0, wdata[4:0]};
    end else if (wr && addr == bci_pkg::ADDR_PORT_CONTROL) begin
      port_control <= wdata[1:0];
    end
  end

  // indirect offset: software write or advance after a window access
  // a refused window access leaves the offset where it is
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      indirect_offset <= bci_pkg::RESET_INDIRECT_OFFSET;
    end else if (wr && addr == bci_pkg::ADDR_INDIRECT_OFFSET) begin
      indirect_offset <= wdata;
    end else if ((wr_data || rd_data) && indirect_control[bci_pkg::POS_AUTO_INC]) begin
      indirect_offset <= indirect_offset + 8'h01;
    end
  end

  // page storage; no reset so it maps onto plain memory
  // the status offset is excluded so a stray write cannot corrupt it
  always_ff @(posedge clk) begin
    if (wr_data && indirect_offset != bci_pkg::STATUS_OFFSET) begin
      page_mem[page_port][indirect_offset] <= wdata;
    end
  end

  // receiver status, sticky; a new event wins over a clearing read
  // events come from logic on clk already, so they need no synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_status[0] <= 8'h00;
      rx_status[1] <= 8'h00;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (rd_data && page_port == p[0] && indirect_offset == bci_pkg::STATUS_OFFSET &&
            indirect_control[bci_pkg::POS_READ_MODE]) begin
          rx_status[p] <= (p == 0) ? rx_event_p0 : rx_event_p1;
        end else begin
          rx_status[p] <= rx_status[p] | ((p == 0) ? rx_event_p0 : rx_event_p1);
        end
      end
    end
  end

  // read data, valid only in the cycle after rd; unmapped reads give zero
  // zero outside the answer cycle lets several banks share one read bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        bci_pkg::ADDR_INDIRECT_CONTROL: rdata <= indirect_control;
        bci_pkg::ADDR_INDIRECT_OFFSET: rdata <= indirect_offset;
        bci_pkg::ADDR_INDIRECT_DATA: rdata <= page_valid ? win_value : 8'h00;
        bci_pkg::ADDR_PORT_CONTROL: rdata <= {6'h00, port_control};
        bci_pkg::ADDR_BRIDGE_CONTROL: rdata <= {cont_clk[tgt], dual_input, input_sel, alt_3d,
                                                lanes[tgt], busy, 1'b0};
        bci_pkg::ADDR_BRIDGE_STATUS: rdata <= bridge_status;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // outputs, all from flip-flops through plain gating
  // port swap and active input share bit 5; the mode picks the meaning
  always_comb begin
    continuous_clk = cont_clk;
    lane_enable_p0 = lane_decode(lanes[0]);
    lane_enable_p1 = lane_decode(lanes[1]);
    dual_input_enable = dual_input;
    active_input_port = input_sel & ~port_control[bci_pkg::POS_INDEPENDENT];
    port_swap = input_sel & port_control[bci_pkg::POS_INDEPENDENT];
    alternate_line_3d = alt_3d;
    reload_busy = busy;
  end
endmodule : bci_top
`default_nettype wire

//--- verif/bci_top_chk.sv
// concurrent checks on the ports of the bridge control register bank
// assumes straps steady around the first reload and one clk domain
`timescale 1ns/1ps
`default_nettype none
module bci_top_chk (
  input wire logic clk, // device clock
  input wire logic rst, // async reset, active high
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [7:0] rdata, // read data
  input wire logic [1:0] mode_strap_a, // lane strap
  input wire logic mode_strap_b, // clock strap
  input wire logic [1:0] continuous_clk, // clock lane mode
  input wire logic [3:0] lane_enable_p0, // port 0 lanes
  input wire logic [3:0] lane_enable_p1, // port 1 lanes
  input wire logic dual_input_enable, // dual input
  input wire logic active_input_port, // active port
  input wire logic port_swap, // crossed routing
  input wire logic alternate_line_3d, // 3d merge
  input wire logic reload_busy // reload running
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // lane field decode, thermometer from lane 0 up
  function automatic logic [3:0] lanes(logic [1:0] f);
    return 4'hf >> (2'd3 - f);
  endfunction : lanes
  // strap values caught when the first reload after reset ends
  logic busy_q;
  logic orig_valid;
  logic [1:0] orig_a;
  logic orig_b;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b1;
      orig_valid <= 1'b0;
      orig_a <= 2'h0;
      orig_b <= 1'b0;
    end else begin
      busy_q <= reload_busy;
      if (!orig_valid && busy_q && !reload_busy) begin
        orig_valid <= 1'b1;
        orig_a <= mode_strap_a;
        orig_b <= mode_strap_b;
      end
    end
  end
  sequence s_busy8;
    reload_busy [*8];
  endsequence
  sequence s_start;
    wr && addr == 8'h4f && wdata[1] && !reload_busy;
  endsequence
  AST_RELOAD_START: assert property (s_start |=> reload_busy)
    else $error("reload did not start");
  AST_RELOAD_LEN: assert property ($rose(reload_busy) |-> s_busy8 ##1 s_busy8 ##1 !reload_busy)
    else $error("reload length wrong");
  AST_STRAP_RESTORE: assert property ($fell(reload_busy) |->
    lane_enable_p0 == lanes(orig_valid ? orig_a : mode_strap_a) &&
    lane_enable_p1 == lane_enable_p0 &&
    continuous_clk == {2{orig_valid ? orig_b : mode_strap_b}})
    else $error("strap fields not restored");
  AST_LANE_P0: assert property (lane_enable_p0 inside {4'h1, 4'h3, 4'h7, 4'hf})
    else $error("port 0 lane enables illegal");
  AST_LANE_P1: assert property (lane_enable_p1 inside {4'h1, 4'h3, 4'h7, 4'hf})
    else $error("port 1 lane enables illegal");
  AST_ROUTE_EXCL: assert property (!(port_swap && active_input_port))
    else $error("swap and port select both set");
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside answer cycle");
  AST_UNMAPPED: assert property (rd && addr > 8'h50 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_FIELD_WRITE: assert property (wr && addr == 8'h4f && !wdata[1] && !reload_busy |=>
    {1'b0, dual_input_enable, 1'b0, alternate_line_3d, 4'h0} == ($past(wdata) & 8'h50))
    else $error("mode bits not taken from write");
endmodule : bci_top_chk
bind bci_top bci_top_chk u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .mode_strap_a(mode_strap_a), .mode_strap_b(mode_strap_b),
  .continuous_clk(continuous_clk), .lane_enable_p0(lane_enable_p0),
  .lane_enable_p1(lane_enable_p1), .dual_input_enable(dual_input_enable),
  .active_input_port(active_input_port), .port_swap(port_swap),
  .alternate_line_3d(alternate_line_3d), .reload_busy(reload_busy));
`default_nettype wire

//--- verif/bridge_control_indirect_access_test.sv
// directed register-port tests of the bridge control bank
// assumes straps stable from time zero until the reload test; rx_event_p0 held idle
`timescale 1ns/1ps
`default_nettype none
module bridge_control_indirect_access_test;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, mode_strap_b = 1'b1, cksum_ok = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rx_event_p0 = 8'h00, rx_event_p1 = 8'h00, rdata;
  logic [1:0] mode_strap_a = 2'h2, continuous_clk;
  logic [3:0] lane_enable_p0, lane_enable_p1;
  logic dual_input_enable, active_input_port, port_swap, alternate_line_3d, reload_busy;
  int error_cnt = 0, compares = 0;
  // page codes that must refuse window access: off, reserved 011, reserved 111
  logic [7:0] off_pages [3] = '{8'h00, 8'h0e, 8'h1e};
  bci_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .mode_strap_a(mode_strap_a), .mode_strap_b(mode_strap_b),
    .cksum_ok(cksum_ok), .rx_event_p0(rx_event_p0), .rx_event_p1(rx_event_p1),
    .continuous_clk(continuous_clk), .lane_enable_p0(lane_enable_p0),
    .lane_enable_p1(lane_enable_p1), .dual_input_enable(dual_input_enable),
    .active_input_port(active_input_port), .port_swap(port_swap),
    .alternate_line_3d(alternate_line_3d), .reload_busy(reload_busy));
  // 100 ns period
  initial forever #50 clk = ~clk;
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // one-cycle write strobe, outputs settle before return
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  // read data only stands in the cycle after the strobe
  task automatic rd_reg(logic [7:0] a, logic [7:0] exp, logic [7:0] mask = 8'hff);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp & mask, rdata & mask);
  endtask : rd_reg
  task automatic wait_reload;
    for (int i = 0; i < 40 && reload_busy !== 1'b0; i++) @(posedge clk);
    #1;
    chk("reload_busy", 8'h00, {7'h0, reload_busy});
  endtask : wait_reload
  task automatic end_of_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // watchdog, tests need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wait_reload();
    rd_reg(8'h4f, 8'h88);
    chk("lanes", 8'h07, {4'h0, lane_enable_p0});
    chk("cclk", 8'h01, {7'h0, continuous_clk[0]});
    rd_reg(8'h50, 8'h16);
    rd_reg(8'h41, 8'h00);
    rd_reg(8'h60, 8'h00);
    wr_reg(8'h40, 8'h06);
    wr_reg(8'h41, 8'h10);
    wr_reg(8'h42, 8'ha5);
    wr_reg(8'h42, 8'h5a);
    rd_reg(8'h41, 8'h12);
    wr_reg(8'h41, 8'h10);
    rd_reg(8'h42, 8'ha5);
    rd_reg(8'h42, 8'h5a);
    rd_reg(8'h41, 8'h12);
    // second page has its own storage
    wr_reg(8'h40, 8'h08);
    wr_reg(8'h41, 8'h10);
    wr_reg(8'h42, 8'h3c);
    rd_reg(8'h42, 8'h3c);
    // off and reserved pages refuse data access
    foreach (off_pages[i]) begin
      wr_reg(8'h40, off_pages[i]);
      wr_reg(8'h42, 8'hff);
      rd_reg(8'h42, 8'h00);
      rd_reg(8'h41, 8'h10);
    end
    wr_reg(8'h40, 8'h04);
    rd_reg(8'h42, 8'ha5);
    // sticky status, cleared only in read mode
    wr_reg(8'h40, 8'h08);
    wr_reg(8'h41, 8'hf0);
    @(posedge clk) rx_event_p1 <= 8'h01;
    @(posedge clk) rx_event_p1 <= 8'h00;
    rd_reg(8'h42, 8'h01);
    rd_reg(8'h42, 8'h01);
    wr_reg(8'h40, 8'h09);
    rd_reg(8'h40, 8'h09);
    rd_reg(8'h42, 8'h01);
    rd_reg(8'h42, 8'h00);
    // every lane code, single input on port 1 with 3d merge
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h4f, {4'h3, i[1:0], 2'h0});
      chk("lanes", 8'h0f >> (3 - i), {4'h0, lane_enable_p0});
      chk("modes", 8'h05, {4'h0, dual_input_enable, active_input_port, port_swap,
        alternate_line_3d});
      rd_reg(8'h4f, {4'h3, i[1:0], 2'h0});
    end
    wr_reg(8'h4f, 8'hc0);
    chk("modes", 8'h08, {4'h0, dual_input_enable, active_input_port, port_swap,
      alternate_line_3d});
    // independent mode, port 1 targeted
    wr_reg(8'h4e, 8'h03);
    rd_reg(8'h4e, 8'h03);
    wr_reg(8'h4f, 8'hac);
    chk("lanes both", 8'hf1, {lane_enable_p1, lane_enable_p0});
    chk("route", 8'h01, {6'h0, active_input_port, port_swap});
    wr_reg(8'h4f, 8'h20);
    chk("cclk", 8'h01, {6'h0, continuous_clk});
    rd_reg(8'h4f, 8'h20);
    wr_reg(8'h4e, 8'h00);
    // reload restores straps, bit clears itself
    // straps move after the first catch; the reload must bring back the old values
    @(posedge clk);
    cksum_ok <= 1'b0;
    mode_strap_a <= 2'h1;
    mode_strap_b <= 1'b0;
    wr_reg(8'h4f, 8'h02);
    chk("reload_busy", 8'h01, {7'h0, reload_busy});
    rd_reg(8'h4f, 8'h02, 8'h02);
    wait_reload();
    rd_reg(8'h4f, 8'h88, 8'h8e);
    chk("lanes both", 8'h77, {lane_enable_p1, lane_enable_p0});
    rd_reg(8'h50, 8'h14);
    end_of_test();
  end
endmodule : bridge_control_indirect_access_test
`default_nettype wire
